// ===== core/ppd_port_p.v
// Decided for this implementation: strobed register access.
`include "ppd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ppd_port_p (
   input  wire        clock,
   input  wire        rstn,
   input  wire [15:0] addr,
   input  wire [7:0]  wdata,
   input  wire        wr,
   input  wire        rd,
   output reg  [7:0]  rdata,
   input  wire [7:0]  pin_in,
   output reg  [7:0]  pin_out,
   output reg  [7:0]  pin_oe,
   input  wire [7:0]  pwm_chan_en,
   input  wire [7:0]  pwm_out,
   input  wire        pwm_shutdown_en,
   input  wire [2:0]  timer_oc_en,
   input  wire [2:0]  timer_out,
   input  wire        serial_one_en,
   input  wire        serial_one_transmit,
   output reg         serial_one_receive,
   output reg         pwm_fault_in,
   output reg  [2:0]  timer_capture_in,
   output reg         irq
);
   reg  [7:0] port_p_output_data_r;
   reg  [7:0] port_p_direction_r;
   reg  [7:0] irq_en_r;
   reg  [7:0] irq_edge_r;
   reg  [7:0] rdata_nxt;
   wire [7:0] irq_flag;
   wire [7:0] mux_drv;
   wire [7:0] mux_oe;
   wire [7:0] irq_clr;
   wire       sel_data;
   wire       sel_dir;
   wire       sel_clr;
   wire       sel_en;
   wire       sel_edge;

   assign sel_data = (addr == `PPD_OFF_DATA);
   assign sel_dir  = (addr == `PPD_OFF_DIR);
   assign sel_clr  = (addr == `PPD_OFF_IRQ_CLR);
   assign sel_en   = (addr == `PPD_OFF_IRQ_EN);
   assign sel_edge = (addr == `PPD_OFF_IRQ_EDGE);

   assign irq_clr   = (wr && sel_clr) ? wdata : 8'h00;

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         port_p_output_data_r <= `PPD_RST_DATA;
         port_p_direction_r   <= `PPD_RST_DIR;
         irq_en_r             <= `PPD_RST_IRQ_EN;
         irq_edge_r           <= `PPD_RST_IRQ_EDGE;
      end else if (wr) begin
         if (sel_data)
            port_p_output_data_r <= wdata;
         if (sel_dir)
            port_p_direction_r <= wdata;
         if (sel_en)
            irq_en_r <= wdata;
         if (sel_edge)
            irq_edge_r <= wdata;
         // level register has no write path
      end
   end

   // read mux, data one cycle after the strobe
   always @* begin
      rdata_nxt = `PPD_RD_NONE;
      if (rd) begin
         case (addr)
            `PPD_OFF_DATA:     rdata_nxt = (port_p_output_data_r & port_p_direction_r) |
                                           (pin_in & ~port_p_direction_r);
            `PPD_OFF_LEVEL:    rdata_nxt = pin_in;
            `PPD_OFF_DIR:      rdata_nxt = port_p_direction_r;
            `PPD_OFF_IRQ_STAT: rdata_nxt = irq_flag;
            `PPD_OFF_IRQ_EN:   rdata_nxt = irq_en_r;
            `PPD_OFF_IRQ_EDGE: rdata_nxt = irq_edge_r;
            default:           rdata_nxt = `PPD_RD_NONE;
         endcase
      end
   end

   ppd_pin_mux #(
      .HAS_TIMER     (0),
      .HAS_SERIAL    (0),
      .SERIAL_DRIVES (0),
      .HAS_SHUTDOWN  (1)
   ) u_mux7 (
      .gpio_data   (port_p_output_data_r[7]),
      .gpio_dir    (port_p_direction_r[7]),
      .pwm_en      (pwm_chan_en[7]),
      .pwm_val     (pwm_out[7]),
      .shutdown_en (pwm_shutdown_en),
      .timer_en    (1'b0),
      .timer_val   (1'b0),
      .serial_en   (1'b0),
      .serial_val  (1'b0),
      .pin_drv     (mux_drv[7]),
      .pin_oe      (mux_oe[7])
   );

   genvar i;
   generate
      for (i = 3; i < 7; i = i + 1) begin : g_pwm_only
         ppd_pin_mux u_mux (
            .gpio_data   (port_p_output_data_r[i]),
            .gpio_dir    (port_p_direction_r[i]),
            .pwm_en      (pwm_chan_en[i]),
            .pwm_val     (pwm_out[i]),
            .shutdown_en (1'b0),
            .timer_en    (1'b0),
            .timer_val   (1'b0),
            .serial_en   (1'b0),
            .serial_val  (1'b0),
            .pin_drv     (mux_drv[i]),
            .pin_oe      (mux_oe[i])
         );
      end
   endgenerate

   ppd_pin_mux #(
      .HAS_TIMER     (1),
      .HAS_SERIAL    (1),
      .SERIAL_DRIVES (1),
      .HAS_SHUTDOWN  (0)
   ) u_mux2 (
      .gpio_data   (port_p_output_data_r[2]),
      .gpio_dir    (port_p_direction_r[2]),
      .pwm_en      (pwm_chan_en[2]),
      .pwm_val     (pwm_out[2]),
      .shutdown_en (1'b0),
      .timer_en    (timer_oc_en[2]),
      .timer_val   (timer_out[2]),
      .serial_en   (serial_one_en),
      .serial_val  (serial_one_transmit),
      .pin_drv     (mux_drv[2]),
      .pin_oe      (mux_oe[2])
   );

   // pin 1, timer but no serial
   ppd_pin_mux #(
      .HAS_TIMER     (1),
      .HAS_SERIAL    (0),
      .SERIAL_DRIVES (0),
      .HAS_SHUTDOWN  (0)
   ) u_mux1 (
      .gpio_data   (port_p_output_data_r[1]),
      .gpio_dir    (port_p_direction_r[1]),
      .pwm_en      (pwm_chan_en[1]),
      .pwm_val     (pwm_out[1]),
      .shutdown_en (1'b0),
      .timer_en    (timer_oc_en[1]),
      .timer_val   (timer_out[1]),
      .serial_en   (1'b0),
      .serial_val  (1'b0),
      .pin_drv     (mux_drv[1]),
      .pin_oe      (mux_oe[1])
   );

   // pin 0, serial receive
   // receive leaves the pin undriven; its level goes back out on serial_one_receive
   ppd_pin_mux #(
      .HAS_TIMER     (1),
      .HAS_SERIAL    (1),
      .SERIAL_DRIVES (0),
      .HAS_SHUTDOWN  (0)
   ) u_mux0 (
      .gpio_data   (port_p_output_data_r[0]),
      .gpio_dir    (port_p_direction_r[0]),
      .pwm_en      (pwm_chan_en[0]),
      .pwm_val     (pwm_out[0]),
      .shutdown_en (1'b0),
      .timer_en    (timer_oc_en[0]),
      .timer_val   (timer_out[0]),
      .serial_en   (serial_one_en),
      .serial_val  (1'b0),
      .pin_drv     (mux_drv[0]),
      .pin_oe      (mux_oe[0])
   );

   // pin interrupt in any mode
   // fed from the raw level, so a driven output that is shorted still flags
   ppd_irq_bit u_irq0 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[0]),
      .rise_sel (irq_edge_r[0]),
      .clear    (irq_clr[0]),
      .flag_r   (irq_flag[0])
   );

   ppd_irq_bit u_irq1 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[1]),
      .rise_sel (irq_edge_r[1]),
      .clear    (irq_clr[1]),
      .flag_r   (irq_flag[1])
   );

   ppd_irq_bit u_irq2 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[2]),
      .rise_sel (irq_edge_r[2]),
      .clear    (irq_clr[2]),
      .flag_r   (irq_flag[2])
   );

   ppd_irq_bit u_irq3 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[3]),
      .rise_sel (irq_edge_r[3]),
      .clear    (irq_clr[3]),
      .flag_r   (irq_flag[3])
   );

   ppd_irq_bit u_irq4 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[4]),
      .rise_sel (irq_edge_r[4]),
      .clear    (irq_clr[4]),
      .flag_r   (irq_flag[4])
   );

   ppd_irq_bit u_irq5 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[5]),
      .rise_sel (irq_edge_r[5]),
      .clear    (irq_clr[5]),
      .flag_r   (irq_flag[5])
   );

   ppd_irq_bit u_irq6 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[6]),
      .rise_sel (irq_edge_r[6]),
      .clear    (irq_clr[6]),
      .flag_r   (irq_flag[6])
   );

   ppd_irq_bit u_irq7 (
      .clock    (clock),
      .rstn     (rstn),
      .level    (pin_in[7]),
      .rise_sel (irq_edge_r[7]),
      .clear    (irq_clr[7]),
      .flag_r   (irq_flag[7])
   );

   // pins and peer inputs are registered, so owner changes show one cycle later
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata              <= 8'h00;
         pin_out            <= 8'h00;
         pin_oe             <= 8'h00;
         serial_one_receive <= 1'b1;
         pwm_fault_in       <= 1'b0;
         timer_capture_in   <= 3'h0;
         irq                <= 1'b0;
      end else begin
         rdata              <= rdata_nxt;
         pin_out            <= mux_drv;
         pin_oe             <= mux_oe;
         serial_one_receive <= serial_one_en ? pin_in[`PPD_BIT_SER_RX] : 1'b1;
         pwm_fault_in       <= pin_in[`PPD_BIT_SHUTDOWN];
         timer_capture_in   <= pin_in[2:0];
         irq                <= |(irq_flag & irq_en_r);
      end
   end
endmodule
`default_nettype wire

// ===== core/ppd_defines.vh
`ifndef PPD_DEFINES_VH
`define PPD_DEFINES_VH

`define PPD_ADDR_W         16
`define PPD_DATA_W         8

`define PPD_OFF_DATA       16'h0258
`define PPD_OFF_LEVEL      16'h025c
`define PPD_OFF_DIR        16'h0260
`define PPD_OFF_IRQ_STAT   16'h0264
`define PPD_OFF_IRQ_CLR    16'h0268
`define PPD_OFF_IRQ_EN     16'h026c
`define PPD_OFF_IRQ_EDGE   16'h0270

`define PPD_RST_DATA       8'h00
`define PPD_RST_DIR        8'h00
`define PPD_RST_IRQ_EN     8'h00
`define PPD_RST_IRQ_EDGE   8'h00
`define PPD_RD_NONE        8'h00

`define PPD_BIT_SHUTDOWN   7
`define PPD_BIT_SER_TX     2
`define PPD_BIT_SER_RX     0

`endif

// ===== core/ppd_pin_mux.v
`timescale 1ns/10ps
`default_nettype none
module ppd_pin_mux #(
   parameter HAS_TIMER = 0,
   parameter HAS_SERIAL = 0,
   parameter SERIAL_DRIVES = 0,
   parameter HAS_SHUTDOWN = 0
) (
   input  wire gpio_data,
   input  wire gpio_dir,
   input  wire pwm_en,
   input  wire pwm_val,
   input  wire shutdown_en,
   input  wire timer_en,
   input  wire timer_val,
   input  wire serial_en,
   input  wire serial_val,
   output reg  pin_drv,
   output reg  pin_oe
);
   // owner chain: shutdown (if HAS_SHUTDOWN), modulator, timer, serial, plain i/o; direction bit is only read here
   always @* begin
      pin_drv = gpio_data;
      pin_oe  = gpio_dir;
      if (HAS_SHUTDOWN != 0 && shutdown_en) begin
         pin_drv = 1'b0;
         pin_oe  = 1'b0;
      end else if (pwm_en) begin
         pin_drv = pwm_val;
         pin_oe  = 1'b1;
      end else if (HAS_TIMER != 0 && timer_en) begin
         pin_drv = timer_val;
         pin_oe  = 1'b1;
      end else if (HAS_SERIAL != 0 && serial_en) begin
         pin_drv = (SERIAL_DRIVES != 0) ? serial_val : 1'b0;
         pin_oe  = (SERIAL_DRIVES != 0) ? 1'b1 : 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== core/ppd_irq_bit.v
`timescale 1ns/10ps
`default_nettype none
module ppd_irq_bit (
   input  wire clock,
   input  wire rstn,
   input  wire level,
   input  wire rise_sel,
   input  wire clear,
   output reg  flag_r
);
   reg level_prev_r;
   wire hit;

   // edge seen whatever the pin direction
   assign hit = rise_sel ? (level & ~level_prev_r) : (~level & level_prev_r);

   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         level_prev_r <= 1'b0;
         flag_r       <= 1'b0;
      end else begin
         level_prev_r <= level;
         // a new edge beats a clear in the same cycle
         if (hit)
            flag_r <= 1'b1;
         else if (clear)
            flag_r <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ===== tb/ppd_port_p_assertions.sv
`include "ppd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module ppd_port_p_assertions (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic [15:0] addr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic [7:0]  pin_in,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   input wire logic [7:0]  pwm_chan_en,
   input wire logic [7:0]  pwm_out,
   input wire logic        pwm_shutdown_en,
   input wire logic [2:0]  timer_oc_en,
   input wire logic [2:0]  timer_out,
   input wire logic        serial_one_en,
   input wire logic        serial_one_transmit,
   input wire logic        irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   AST_LEVEL_RD: assert property (rd && addr == `PPD_OFF_LEVEL |=> rdata == $past(pin_in))
      else $error("pin level read wrong");
   AST_RD_IDLE: assert property (rd ##1 !rd |=> rdata == 8'h00)
      else $error("read data not cleared");
   AST_SHUTDOWN: assert property (pwm_shutdown_en |=> !pin_oe[7])
      else $error("pin 7 driven in shutdown");
   property p_pwm_seven;
      pwm_chan_en[7] && !pwm_shutdown_en |=> pin_oe[7] && pin_out[7] == $past(pwm_out[7]);
   endproperty
   AST_PWM_SEVEN: assert property (p_pwm_seven)
      else $error("pin 7 not modulator");
   AST_PWM_HIGH: assert property (pwm_chan_en[5] |=> pin_oe[5] && pin_out[5] == $past(pwm_out[5]))
      else $error("pin 5 not modulator");
   AST_PWM_LOW: assert property (pwm_chan_en[2] |=> pin_oe[2] && pin_out[2] == $past(pwm_out[2]))
      else $error("pin 2 not modulator");
   property p_timer_one;
      !pwm_chan_en[1] && timer_oc_en[1] |=> pin_oe[1] && pin_out[1] == $past(timer_out[1]);
   endproperty
   AST_TIMER_ONE: assert property (p_timer_one)
      else $error("pin 1 not timer");
   property p_timer_zero;
      !pwm_chan_en[0] && timer_oc_en[0] |=> pin_oe[0] && pin_out[0] == $past(timer_out[0]);
   endproperty
   AST_TIMER_ZERO: assert property (p_timer_zero)
      else $error("pin 0 not timer");
   property p_ser_tx;
      !pwm_chan_en[2] && !timer_oc_en[2] && serial_one_en |=> pin_oe[2] && pin_out[2] == $past(serial_one_transmit);
   endproperty
   AST_SER_TX: assert property (p_ser_tx)
      else $error("pin 2 not transmit");
   AST_SER_RX: assert property (!pwm_chan_en[0] && !timer_oc_en[0] && serial_one_en |=> !pin_oe[0])
      else $error("pin 0 driven as receive");
   cover property (pwm_shutdown_en && pwm_chan_en[7]);
   cover property (serial_one_en && !timer_oc_en[2] && !pwm_chan_en[2]);
   cover property ($rose(irq));
endmodule
bind ppd_port_p ppd_port_p_assertions u_chk (.clock, .rstn, .addr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
   .pwm_chan_en, .pwm_out, .pwm_shutdown_en, .timer_oc_en, .timer_out, .serial_one_en, .serial_one_transmit, .irq);
`default_nettype wire

// ===== tb/test_ppd_port_p.sv
`include "ppd_defines.vh"
`timescale 1ns/10ps
`default_nettype none
module test_ppd_port_p;
   logic        clock = 0, rstn = 0, wr = 0, rd = 0, live = 0;
   logic        pwm_shutdown_en = 0, serial_one_en = 0, serial_one_transmit = 0;
   logic [15:0] addr = '0;
   logic [7:0]  wdata = '0, pin_in = '0, pwm_chan_en = '0, pwm_out = '0;
   logic [2:0]  timer_oc_en = '0, timer_out = '0;
   wire  [7:0]  rdata, pin_out, pin_oe;
   wire  [2:0]  timer_capture_in;
   wire         serial_one_receive, pwm_fault_in, irq;
   logic [7:0]  data_m, dir_m, stat_m, en_m, edge_m, prev_m, ev, erd, eoe, eout;
   logic [5:0]  eside;
   logic [31:0] r;
   integer      seed = 32'hdd0dd777, num_errors = 0, tests_run = 0, i, n;
   logic [15:0] map [8] = '{`PPD_OFF_DATA, `PPD_OFF_LEVEL, `PPD_OFF_DIR, `PPD_OFF_IRQ_STAT,
                            `PPD_OFF_IRQ_CLR, `PPD_OFF_IRQ_EN, `PPD_OFF_IRQ_EDGE, 16'h0274};

   ppd_port_p u_ppd_port_p (.clock, .rstn, .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out, .pin_oe,
      .pwm_chan_en, .pwm_out, .pwm_shutdown_en, .timer_oc_en, .timer_out, .serial_one_en,
      .serial_one_transmit, .serial_one_receive, .pwm_fault_in, .timer_capture_in, .irq);

   always #2.5 clock = ~clock;

   task cmp(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   task test_done;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // model works on values sampled before this edge's updates land
   always @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         {data_m, dir_m, stat_m, en_m, edge_m, prev_m} = '0;
         live = 1'b0;
      end else begin
         eoe = dir_m;
         eout = data_m;
         if (serial_one_en) {eoe[2], eout[2], eoe[0]} = {1'b1, serial_one_transmit, 1'b0};
         for (i = 0; i < 3; i++) if (timer_oc_en[i]) {eoe[i], eout[i]} = {1'b1, timer_out[i]};
         for (i = 0; i < 8; i++) if (pwm_chan_en[i]) {eoe[i], eout[i]} = {1'b1, pwm_out[i]};
         if (pwm_shutdown_en) eoe[7] = 1'b0;
         erd = '0;
         if (rd) case (addr)
            `PPD_OFF_DATA:     erd = (data_m & dir_m) | (pin_in & ~dir_m);
            `PPD_OFF_LEVEL:    erd = pin_in;
            `PPD_OFF_DIR:      erd = dir_m;
            `PPD_OFF_IRQ_STAT: erd = stat_m;
            `PPD_OFF_IRQ_EN:   erd = en_m;
            `PPD_OFF_IRQ_EDGE: erd = edge_m;
            default:           erd = '0;
         endcase
         eside = {|(stat_m & en_m), pin_in[7], serial_one_en ? pin_in[0] : 1'b1, pin_in[2:0]};
         ev = (edge_m & pin_in & ~prev_m) | (~edge_m & ~pin_in & prev_m);
         prev_m = pin_in;
         if (wr) case (addr)
            `PPD_OFF_DATA:     data_m = wdata;
            `PPD_OFF_DIR:      dir_m = wdata;
            `PPD_OFF_IRQ_CLR:  stat_m = stat_m & ~wdata;
            `PPD_OFF_IRQ_EN:   en_m = wdata;
            `PPD_OFF_IRQ_EDGE: edge_m = wdata;
            default:           ;
         endcase
         stat_m = stat_m | ev;
         live = 1'b1;
      end
   end

   always @(negedge clock) if (live) begin
      cmp("rdata", erd, rdata);
      cmp("pin_oe", eoe, pin_oe);
      cmp("pin_out", eout & eoe, pin_out & eoe);
      cmp("side", {2'b00, eside}, {2'b00, irq, pwm_fault_in, serial_one_receive, timer_capture_in});
   end

   // sparse modulator and timer enables so plain i/o still gets most of the pins; serial is on half the time
   initial begin
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      for (n = 0; n < 4000; n++) begin
         @(posedge clock);
         // one reset pulse mid-run, registers must come back cleared
         rstn <= (n != 2000);
         r = $random(seed);
         pin_in <= $random(seed);
         pwm_chan_en <= $random(seed) & $random(seed) & $random(seed);
         pwm_out <= $random(seed);
         pwm_shutdown_en <= r[0] & r[1] & r[2];
         serial_one_en <= r[3];
         serial_one_transmit <= r[4];
         timer_oc_en <= r[7:5] & r[10:8];
         timer_out <= r[13:11];
         wr <= r[14] & r[15];
         rd <= r[14] & ~r[15];
         addr <= map[r[18:16]];
         wdata <= r[26:19];
      end
      test_done;
   end
endmodule
`default_nettype wire
